/* rtl/vpn_nest.sv */
// priority, nesting and vector logic of the interrupt controller
// What this block does
// RQ1: pin interrupts 0-3 have writable 3-bit priorities in group two
// RQ2: logic array 0, supply, comparator, serial priorities in group two
// RQ3: group three holds pwm priority bits 6:4, logic array 1 bits 2:0
// RQ4: nesting control bit 0 enables normal nesting, bit 1 fast nesting
// RQ5: nesting off: still delivered, priorities ignored, fast beats normal
// RQ6: normal vector read with nesting sets in-service bit of winner priority
// RQ7: normal in-service bit blocks normal requests of same or lower priority
// RQ8: write to normal in-service status clears only highest-priority set bit
// RQ9: fast vector read with nesting sets fast in-service bit of its priority
// RQ10: set fast in-service bit blocks fast requests of same or lower priority
// RQ11: write to fast in-service status clears only highest-priority set bit
// RQ12: fast vector reads zero, base at 22:7, source at 6:2, zero at 1:0
// RQ13: software reads fast vector only in a fast handler with nesting on
// RQ14: normal vector has the same layout as the fast vector
// RQ15: 16-bit table base register appears in both vector registers
// RQ16: priority value 0 is highest; with nesting on the lowest value wins arbitration
// RQ17: reserved bits read as zero and ignore writes
// RQ18: software writes in-service status once at end of each nested handler
module vpn_nest
  import vpn_pkg::*;
(
  input wire logic REF_CLK, // system clock, 100 MHz
  input wire logic RST_N, // asynchronous reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction, high for write
  input wire logic [31:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb transfer done
  output logic PSLVERR, // apb unmapped address
  input wire logic [9:0] IRQ_SRC, // pending enabled normal sources
  input wire logic [9:0] FIQ_SRC, // pending enabled fast sources
  output logic IRQ_OUT, // normal interrupt request to the core
  output logic FIQ_OUT // fast interrupt request to the core
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // bits 0..p set: in-service levels that block priority p
  function automatic logic [7:0] vpn_le_mask(input logic [2:0] p);
    logic [8:0] m;
    m = (9'h002 << p) - 9'h001;
    return m[7:0];
  endfunction : vpn_le_mask

  // isolate the lowest set bit, the highest priority level in service
  function automatic logic [7:0] vpn_low_bit(input logic [7:0] s);
    return s & (~s + 8'h01);
  endfunction : vpn_low_bit

  // pick the winner: {valid, index, priority}
  function automatic logic [7:0] vpn_arb(
    input logic [9:0] pend,
    input logic [29:0] pri,
    input logic [7:0] stat,
    input logic nest
  );
    logic found;
    logic [3:0] idx;
    logic [2:0] bp;
    logic [2:0] p;
    found = 1'b0;
    idx = 4'h0;
    bp = 3'h0;
    p = 3'h0;
    for (int i = 0; i < VPN_NSRC; i++)
    begin
      p = pri[i*3 +: 3];
      if (pend[i] && (!nest || ((stat & vpn_le_mask(p)) == 8'h00)) &&
          (!found || (nest && (p < bp)))) // RQ16 RQ5
      begin
        found = 1'b1;
        idx = 4'(i);
        bp = p;
      end
    end
    return {found, idx, bp};
  endfunction : vpn_arb

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0] pri2_q;
  logic [31:0] pri3_q;
  logic [1:0] nest_q;
  logic [15:0] base_q;
  logic [7:0] nstat_q;
  logic [7:0] nstat_d;
  logic [7:0] fstat_q;
  logic [7:0] fstat_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic fiq_q;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire acc = PSEL & PENABLE & ~pready_q;
  wire wr = acc & PWRITE;
  wire rd = acc & ~PWRITE;
  wire hit_base = (PADDR == VPN_OFS_BASE);
  wire hit_nvec = (PADDR == VPN_OFS_NVEC);
  wire hit_pri2 = (PADDR == VPN_OFS_PRI2);
  wire hit_pri3 = (PADDR == VPN_OFS_PRI3);
  wire hit_nest = (PADDR == VPN_OFS_NEST);
  wire hit_nstat = (PADDR == VPN_OFS_NSTAT);
  wire hit_fvec = (PADDR == VPN_OFS_FVEC);
  wire hit_fstat = (PADDR == VPN_OFS_FSTAT);
  wire hit_any = hit_base | hit_nvec | hit_pri2 | hit_pri3 | hit_nest |
                 hit_nstat | hit_fvec | hit_fstat;

  // ************************************************************
  // priority table and arbitration
  // ************************************************************
  wire [29:0] pri_all = {
    pri3_q[VPN_PWM_LSB +: 3], // RQ3
    pri2_q[VPN_SERIAL_LSB +: 3], // RQ2
    pri2_q[VPN_CMP_LSB +: 3],
    pri2_q[VPN_SUPPLY_LSB +: 3],
    pri3_q[VPN_LA1_LSB +: 3], // RQ3
    pri2_q[VPN_LA0_LSB +: 3],
    pri2_q[VPN_PIN3_LSB +: 3], // RQ1
    pri2_q[VPN_PIN2_LSB +: 3],
    pri2_q[VPN_PIN1_LSB +: 3],
    pri2_q[VPN_PIN0_LSB +: 3]
  };
  wire nest_n = nest_q[VPN_NORMAL_NEST_BIT]; // RQ4
  wire nest_f = nest_q[VPN_FAST_NEST_BIT]; // RQ4
  wire [7:0] arb_n = vpn_arb(IRQ_SRC, pri_all, nstat_q, nest_n); // RQ7
  wire [7:0] arb_f = vpn_arb(FIQ_SRC, pri_all, fstat_q, nest_f); // RQ10
  wire irq_v = arb_n[7];
  wire fiq_v = arb_f[7];
  wire [2:0] irq_pri = arb_n[2:0];
  wire [2:0] fiq_pri = arb_f[2:0];
  wire [4:0] irq_num = VPN_SRC_NUM[arb_n[6:3]];
  wire [4:0] fiq_num = VPN_SRC_NUM[arb_f[6:3]];

  // ************************************************************
  // vector words and read mux
  // ************************************************************
  wire [31:0] nvec = {9'h000, base_q, irq_num, 2'h0}; // RQ14 RQ15
  wire [31:0] fvec = {9'h000, base_q, fiq_num, 2'h0}; // RQ12 RQ15
  wire [31:0] rd_data =
    hit_base ? {16'h0000, base_q} :
    hit_nvec ? nvec :
    hit_pri2 ? pri2_q :
    hit_pri3 ? pri3_q :
    hit_nest ? {30'h0000_0000, nest_q} :
    hit_nstat ? {24'h00_0000, nstat_q} :
    hit_fvec ? fvec :
    hit_fstat ? {24'h00_0000, fstat_q} :
    32'h0000_0000; // RQ17

  // ************************************************************
  // in-service status next values
  // ************************************************************
  wire [7:0] nset = (rd & hit_nvec & nest_n & irq_v) ?
                    (8'h01 << irq_pri) : 8'h00; // RQ6
  wire [7:0] fset = (rd & hit_fvec & nest_f & fiq_v) ?
                    (8'h01 << fiq_pri) : 8'h00; // RQ9
  wire [7:0] nclr = (wr & hit_nstat) ? vpn_low_bit(nstat_q) : 8'h00; // RQ8
  wire [7:0] fclr = (wr & hit_fstat) ? vpn_low_bit(fstat_q) : 8'h00; // RQ11
  // a set wins over a clear in the same cycle
  assign nstat_d = (nstat_q & ~nclr) | nset;
  assign fstat_d = (fstat_q & ~fclr) | fset;

  // ************************************************************
  // configuration registers
  // ************************************************************

  // software writable fields, reserved bits masked off
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pri2_q <= VPN_RST_PRI;
      pri3_q <= VPN_RST_PRI;
      nest_q <= VPN_RST_NEST;
      base_q <= VPN_RST_BASE;
    end
    else
    begin
      if (wr & hit_pri2)
        pri2_q <= PWDATA & VPN_MASK_PRI2; // RQ1 RQ2 RQ17
      if (wr & hit_pri3)
        pri3_q <= PWDATA & VPN_MASK_PRI3; // RQ3 RQ17
      if (wr & hit_nest)
        nest_q <= PWDATA[1:0]; // RQ4
      if (wr & hit_base)
        base_q <= PWDATA[15:0]; // RQ15
    end
  end

  // in-service status registers
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      nstat_q <= VPN_RST_STAT;
      fstat_q <= VPN_RST_STAT;
    end
    else
    begin
      nstat_q <= nstat_d;
      fstat_q <= fstat_d;
    end
  end

  // ************************************************************
  // bus answer and request outputs
  // ************************************************************

  // one wait state, then data and ready together
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc & ~hit_any;
      prdata_q <= rd ? rd_data : 32'h0000_0000;
    end
  end

  // fast request holds off the normal one
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_q <= 1'b0;
      fiq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_v & ~fiq_v; // RQ5
      fiq_q <= fiq_v;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ_OUT = irq_q;
  assign FIQ_OUT = fiq_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  a_nvec_sets_stat: assert property ( // RQ6
    (rd && hit_nvec && nest_n && irq_v) |=>
      ((nstat_q & $past(8'h01 << irq_pri)) != 8'h00))
    else $error("normal vector read did not set in-service bit");

  a_fvec_sets_stat: assert property ( // RQ9
    (rd && hit_fvec && nest_f && fiq_v) |=>
      ((fstat_q & $past(8'h01 << fiq_pri)) != 8'h00))
    else $error("fast vector read did not set in-service bit");

  a_nstat_clear_one: assert property ( // RQ8
    (wr && hit_nstat) |=> nstat_q == ($past(nstat_q) & ($past(nstat_q) -
      8'h01)))
    else $error("normal in-service clear removed wrong bits");

  a_fstat_clear_one: assert property ( // RQ11
    (wr && hit_fstat) |=> fstat_q == ($past(fstat_q) & ($past(fstat_q) -
      8'h01)))
    else $error("fast in-service clear removed wrong bits");

  a_irq_blocked: assert property ( // RQ7
    (nest_n && irq_v) |-> ((nstat_q & vpn_le_mask(irq_pri)) == 8'h00))
    else $error("normal winner not above in-service level");

  a_fiq_blocked: assert property ( // RQ10
    (nest_f && fiq_v) |-> ((fstat_q & vpn_le_mask(fiq_pri)) == 8'h00))
    else $error("fast winner not above in-service level");

  a_fast_first: assert property ( // RQ5
    (fiq_v && irq_v) |=> (FIQ_OUT && !IRQ_OUT))
    else $error("normal request not held off by fast request");

  a_nonest_keep: assert property ( // RQ5
    (!nest_n && !(wr && hit_nstat)) |=> $stable(nstat_q))
    else $error("normal in-service changed with nesting off");

  a_fvec_layout: assert property ( // RQ12
    (rd && hit_fvec) |=> (PREADY && PRDATA[31:23] == 9'h000 &&
      PRDATA[22:7] == base_q && PRDATA[1:0] == 2'h0))
    else $error("fast vector word has wrong layout");

  a_resv_zero: assert property ( // RQ17
    (rd && hit_pri3) |=> (PRDATA[31:7] == 25'h000_0000 && !PRDATA[3]))
    else $error("reserved bits of group three read nonzero");

endmodule : vpn_nest

/* rtl/vpn_pkg.sv */
// constants for the priority and nesting part of the interrupt controller
package vpn_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [31:0] VPN_OFS_BASE = 32'hffff_0014;
  localparam logic [31:0] VPN_OFS_NVEC = 32'hffff_001c;
  localparam logic [31:0] VPN_OFS_PRI2 = 32'hffff_0028;
  localparam logic [31:0] VPN_OFS_PRI3 = 32'hffff_002c;
  localparam logic [31:0] VPN_OFS_NEST = 32'hffff_0030;
  localparam logic [31:0] VPN_OFS_NSTAT = 32'hffff_003c;
  localparam logic [31:0] VPN_OFS_FVEC = 32'hffff_011c;
  localparam logic [31:0] VPN_OFS_FSTAT = 32'hffff_013c;

  // ************************************************************
  // reset values and writable bit masks
  // ************************************************************
  localparam logic [31:0] VPN_RST_PRI = 32'h0000_0000;
  localparam logic [1:0] VPN_RST_NEST = 2'h0;
  localparam logic [7:0] VPN_RST_STAT = 8'h00;
  localparam logic [15:0] VPN_RST_BASE = 16'h0000;
  localparam logic [31:0] VPN_MASK_PRI2 = 32'h7777_7777;
  localparam logic [31:0] VPN_MASK_PRI3 = 32'h0000_0077;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int VPN_NORMAL_NEST_BIT = 0;
  localparam int VPN_FAST_NEST_BIT = 1;
  localparam int VPN_VEC_BASE_LSB = 7;
  localparam int VPN_VEC_SRC_LSB = 2;
  // priority field lsb of each source, source index order:
  // pin0 pin1 pin2 pin3 logic_array0 logic_array1 supply cmp serial pwm
  localparam int VPN_PIN0_LSB = 4;
  localparam int VPN_PIN1_LSB = 16;
  localparam int VPN_PIN2_LSB = 24;
  localparam int VPN_PIN3_LSB = 28;
  localparam int VPN_LA0_LSB = 20;
  localparam int VPN_SUPPLY_LSB = 12;
  localparam int VPN_CMP_LSB = 8;
  localparam int VPN_SERIAL_LSB = 0;
  localparam int VPN_PWM_LSB = 4;
  localparam int VPN_LA1_LSB = 0;

  // ************************************************************
  // sources and their vector numbers
  // ************************************************************
  localparam int VPN_NSRC = 10;
  // source numbers reported in the vector, index 9 first
  localparam logic [9:0][4:0] VPN_SRC_NUM = {
    5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c
  };

endpackage : vpn_pkg

/* sim/vpn_core_model.sv */
// processor core model that takes normal and fast requests
module vpn_core_model
(
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic slow, // high for a slow response
  input wire logic irq, // normal request from the controller
  input wire logic fiq, // fast request from the controller
  input wire logic done, // handler has taken its vector
  output logic irq_mode, // core runs a normal handler
  output logic fiq_mode // core runs a fast handler
);
  // ******************************
  // handler entry
  // ******************************
  logic [2:0] wait_q;

  // a request must stand for the response time before entry;
  // the core picks a fast request over a normal one, and a fast
  // request preempts a running normal handler, never the reverse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 3'h0;
      irq_mode <= 1'b0;
      fiq_mode <= 1'b0;
    end
    else if (done)
    begin
      wait_q <= 3'h0;
      irq_mode <= 1'b0;
      fiq_mode <= 1'b0;
    end
    else if (!(irq || fiq) || fiq_mode || (irq_mode && !fiq))
      wait_q <= 3'h0;
    else if (wait_q < (slow ? 3'h5 : 3'h0))
      wait_q <= wait_q + 3'h1;
    else
    begin
      fiq_mode <= fiq;
      irq_mode <= !fiq;
    end
  end
endmodule : vpn_core_model

/* sim/tb_vic_priority_nesting.sv */
// self-checking bench for the priority and nesting block
module tb_vic_priority_nesting
  import vpn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ******************************
  // signals and instances
  // ******************************
  logic REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [31:0] PADDR, PWDATA, PRDATA, v;
  logic [9:0] IRQ_SRC, FIQ_SRC;
  logic IRQ_OUT, FIQ_OUT, slow, done, irq_mode, fiq_mode;
  logic [15:0] base_v;
  logic [33:0] e;
  logic [33:0] expq[$];
  logic [31:0] rw_a [6];
  int failures, checked, cycles, seed;

  vpn_nest vpn_nest_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ_SRC(IRQ_SRC), .FIQ_SRC(FIQ_SRC), .IRQ_OUT(IRQ_OUT),
    .FIQ_OUT(FIQ_OUT));
  vpn_core_model vpn_core_model_inst (.clk(REF_CLK), .rst_n(RST_N),
    .slow(slow), .irq(IRQ_OUT), .fiq(FIQ_OUT), .done(done),
    .irq_mode(irq_mode), .fiq_mode(fiq_mode));

  // clock and cycle ceiling
  initial
  begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      summarize();
    end
  end

  // ******************************
  // tasks
  // ******************************
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // one apb transfer; the expected answer is noted for the monitor
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [31:0] x, input logic err);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    expq.push_back({!w, err, x});
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
    input logic r = 0);
    apb(1'b1, a, d, 32'h0000_0000, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] x,
    input logic r = 0);
    apb(1'b0, a, 32'h0000_0000, x, r);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : idle

  task automatic src(input logic f, input logic [9:0] s);
    @(posedge REF_CLK);
    IRQ_SRC <= f ? 10'h000 : s;
    FIQ_SRC <= f ? s : 10'h000;
  endtask : src

  task automatic out_is(input logic f, input logic x);
    chk("req_out", {31'h0, f ? FIQ_OUT : IRQ_OUT}, {31'h0, x});
  endtask : out_is

  // wait for the core model to enter a handler of the class
  task automatic take(input logic f);
    int i;
    i = 0;
    while ((f ? fiq_mode : irq_mode) !== 1'b1 && i < 60)
    begin
      @(posedge REF_CLK);
      i++;
    end
    chk("core_mode", {31'h0, f ? fiq_mode : irq_mode}, 32'h0000_0001);
  endtask : take

  task automatic ack();
    @(posedge REF_CLK);
    done <= 1'b1;
    @(posedge REF_CLK);
    done <= 1'b0;
  endtask : ack

  function automatic logic [31:0] vec(input int i);
    return {9'h000, base_v, VPN_SRC_NUM[i], 2'h0};
  endfunction : vec

  // nested handling of one class: entry, blocking, ordered clear
  task automatic nest_run(input logic f);
    logic [31:0] va, sa;
    va = f ? VPN_OFS_FVEC : VPN_OFS_NVEC;
    sa = f ? VPN_OFS_FSTAT : VPN_OFS_NSTAT;
    slow <= f;
    wr(VPN_OFS_NEST, 32'h0000_0003);
    wr(VPN_OFS_PRI2, 32'h5000_0036);
    src(f, 10'h109);
    take(f);
    rd(va, vec(0));
    ack();
    rd(sa, 32'h0000_0008);
    out_is(f, 1'b0);
    src(f, 10'h10b);
    take(f);
    rd(va, vec(1));
    ack();
    rd(sa, 32'h0000_0009);
    wr(sa, 32'h0000_00ff);
    rd(sa, 32'h0000_0008);
    wr(sa, 32'h0000_00ff);
    rd(sa, 32'h0000_0000);
    src(f, 10'h000);
    ack();
    wr(VPN_OFS_NEST, 32'h0000_0000);
  endtask : nest_run

  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // monitor: each apb answer is compared with the oldest note
  always @(posedge REF_CLK)
    if (PREADY === 1'b1 && expq.size() > 0)
    begin
      e = expq.pop_front();
      chk("pslverr", {31'h0, PSLVERR}, {31'h0, e[32]});
      if (e[33])
        chk("prdata", PRDATA, e[31:0]);
    end

  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    {PSEL, PENABLE, PWRITE, slow, done, RST_N} = 6'h00;
    {PADDR, PWDATA} = 64'h0;
    {IRQ_SRC, FIQ_SRC} = 20'h0;
    seed = 68;
    base_v = 16'h0000;
    rw_a = '{VPN_OFS_BASE, VPN_OFS_PRI2, VPN_OFS_PRI3, VPN_OFS_NEST,
      VPN_OFS_NSTAT, VPN_OFS_FSTAT};
    idle(5);
    RST_N <= 1'b1;
    foreach (rw_a[i])
      rd(rw_a[i], 32'h0000_0000);
    rd(VPN_OFS_NVEC, vec(0));
    rd(VPN_OFS_FVEC, vec(0));
    rd(32'hffff_0034, 32'h0000_0000, 1'b1);
    wr(32'hffff_0034, 32'hffff_ffff, 1'b1);
    $display("test 1 done");
    repeat (4)
    begin
      v = $random(seed);
      wr(VPN_OFS_PRI2, v);
      rd(VPN_OFS_PRI2, v & VPN_MASK_PRI2);
      wr(VPN_OFS_PRI3, v);
      rd(VPN_OFS_PRI3, v & 32'h0000_0077);
      wr(VPN_OFS_NEST, v);
      rd(VPN_OFS_NEST, v & 32'h0000_0003);
    end
    wr(VPN_OFS_NEST, 32'h0000_0000);
    $display("test 2 done");
    wr(VPN_OFS_BASE, 32'hffff_abcd);
    base_v = 16'habcd;
    rd(VPN_OFS_BASE, 32'h0000_abcd);
    wr(VPN_OFS_FVEC, 32'h0000_0000);
    rd(VPN_OFS_FVEC, vec(0));
    $display("test 3 done");
    wr(VPN_OFS_PRI2, 32'h7000_0000);
    src(1'b0, 10'h108);
    idle(2);
    out_is(1'b0, 1'b1);
    rd(VPN_OFS_NVEC, vec(3));
    rd(VPN_OFS_NSTAT, 32'h0000_0000);
    FIQ_SRC <= 10'h020;
    idle(3);
    out_is(1'b0, 1'b0);
    out_is(1'b1, 1'b1);
    take(1'b1);
    src(1'b0, 10'h000);
    ack();
    $display("test 4 done");
    nest_run(1'b0);
    $display("test 5 done");
    nest_run(1'b1);
    $display("test 6 done");
    idle(4);
    summarize();
  end
endmodule : tb_vic_priority_nesting
